// File: shared/tsb_pkg.sv
// package for the test status and retirement timeout block
package tsb_pkg;

  // one billion cycles without retirement raises a timeout
  localparam int unsigned TIMEOUT_CYCLES = 1_000_000_000;
  // width of the timeout announcement pulse in core clock cycles
  localparam int unsigned PULSE_CYCLES   = 256;
  localparam int          CNT_W          = 30;
  localparam int          PULSE_W        = 9;
  localparam logic        STATUS_RST     = 1'b0;

  // self-test result handed in by the cache test engine
  typedef struct packed {
    logic start;
    logic done;
    logic pass;
  } tsb_bist_type;

  typedef enum logic [1:0] {
    TSB_IDLE,
    TSB_RUN,
    TSB_FAIL
  } tsb_state_type;

endpackage

// File: verilog/tsb_test_status.sv
// test status pin driver: self-test result and retirement timeout pulse
// Contract
// - status low while system reset held
// - status high when cache self-test starts
// - passing self-test returns status low
// - failing self-test keeps status high
// - timeout after one billion idle cycles
// - reset held until supply good; then self-test
`timescale 1ns/100ps
module tsb_test_status #(
  parameter int unsigned TIMEOUT_LIMIT = tsb_pkg::TIMEOUT_CYCLES
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // supply good pin, asynchronous
  input  wire logic              supply_good_in,
  // core events, same clock
  input  wire tsb_pkg::tsb_bist_type bist,
  input  wire logic              retire,
  // open-drain status pin, internal timeout reset and sequence start pulse
  output logic                   test_status_out,
  output logic                   test_status_oe,
  output logic                   timeout_reset,
  output logic                   seq_start
);
  import tsb_pkg::*;

  // refuse a limit the counter cannot reach; a limit of 1 would fire
  // on every idle cycle and leave no span for a retire to land in
  if (TIMEOUT_LIMIT < 2 ||
      TIMEOUT_LIMIT > (2**CNT_W - 1)) begin : g_bad_limit
    $error("TIMEOUT_LIMIT out of range");
  end

  localparam logic [CNT_W-1:0]   LIMIT_M1 = CNT_W'(TIMEOUT_LIMIT - 1);
  localparam logic [PULSE_W-1:0] PULSE_N  = PULSE_W'(PULSE_CYCLES);

  // two-flop synchroniser for the supply good pin; only the second
  // flop feeds logic, the first may still be settling
  logic sg_meta_q, sg_sync_q, sg_seen_q;
  logic sg_seen_d, seq_start_d;
  tsb_state_type     state_q, state_d;
  logic [CNT_W-1:0]   idle_q, idle_d;
  logic [PULSE_W-1:0] pulse_q, pulse_d;
  logic               tmo_q, tmo_d;
  logic               stat_q, stat_d;
  // enable is registered too, so the pin never glitches on a release
  logic               oe_q, oe_d;
  logic               start_q;

  // sequence starts once after reset release with supply good seen
  // a supply glitch after that is ignored until the next reset
  always_comb begin
    sg_seen_d   = sg_seen_q | sg_sync_q;
    seq_start_d = sg_sync_q & ~sg_seen_q;
  end

  // self-test state; a start during any state restarts the test
  // done and pass mean nothing outside a running test
  always_comb begin
    state_d = state_q;
    case (state_q)
      TSB_IDLE: if (bist.start) state_d = TSB_RUN;
      TSB_RUN: begin
        // a start in the same cycle wins and the done is dropped
        if (!bist.start && bist.done) begin
          state_d = bist.pass ? TSB_IDLE : TSB_FAIL;
        end
      end
      TSB_FAIL: if (bist.start) state_d = TSB_RUN;
      default:  state_d = TSB_IDLE;
    endcase
  end

  // idle counter; a retire in the timeout cycle still clears it
  always_comb begin
    tmo_d  = 1'b0;
    idle_d = idle_q + 1'b1;
    if (retire) begin
      idle_d = '0;
    end else if (idle_q == LIMIT_M1) begin
      idle_d = '0;
      tmo_d  = 1'b1;
    end
  end

  // pulse counter; a new timeout mid-pulse restarts the full width
  // so the tester always sees one whole announcement at the end
  always_comb begin
    pulse_d = pulse_q;
    if (tmo_q) begin
      pulse_d = PULSE_N;
    end else if (pulse_q != '0) begin
      pulse_d = pulse_q - 1'b1;
    end
  end

  // status: high while testing, after failure, or during the pulse
  always_comb begin
    stat_d = (state_d != TSB_IDLE) | (pulse_d != '0);
    // open drain: pull low while status is low, let go for a high
    oe_d   = ~stat_d;
  end

  // every state register but the check helpers; reset forces the pin low and driven
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sg_meta_q <= 1'b0;
      sg_sync_q <= 1'b0;
      sg_seen_q <= 1'b0;
      start_q   <= 1'b0;
      state_q   <= TSB_IDLE;
      idle_q    <= '0;
      pulse_q   <= '0;
      tmo_q     <= 1'b0;
      stat_q    <= STATUS_RST;
      oe_q      <= ~STATUS_RST;
    end else begin
      sg_meta_q <= supply_good_in;
      sg_sync_q <= sg_meta_q;
      sg_seen_q <= sg_seen_d;
      start_q   <= seq_start_d;
      state_q   <= state_d;
      idle_q    <= idle_d;
      pulse_q   <= pulse_d;
      tmo_q     <= tmo_d;
      stat_q    <= stat_d;
      oe_q      <= oe_d;
    end
  end

  // level is only driven while low; the board pull-up makes the high,
  // so a tester sampling right after a release may see a slow edge
  assign test_status_out = stat_q;
  assign test_status_oe  = oe_q;
  assign timeout_reset   = tmo_q;
  assign seq_start       = start_q;

  // helper counters for the pulse checks: the high run seen while idle,
  // and the age of the newest pulse; a fresh timeout restarts both,
  // since a timeout inside a pulse legally stretches the high time
  localparam logic [PULSE_W:0] AGE_END = (PULSE_W+1)'(PULSE_CYCLES + 1);
  logic [PULSE_W:0] hi_run_q, hi_run_d;
  logic [PULSE_W:0] age_q, age_d;

  always_comb begin
    hi_run_d = '0;
    age_d    = '0;
    if (tmo_q) begin
      age_d = (PULSE_W+1)'(1);
    end else if (age_q != '0 && age_q != AGE_END) begin
      age_d = age_q + 1'b1;
    end
    if (!tmo_q && stat_q && state_q == TSB_IDLE) begin
      hi_run_d = hi_run_q + 1'b1;
    end
  end

  // helper registers, cleared with the block
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hi_run_q <= '0;
      age_q    <= '0;
    end else begin
      hi_run_q <= hi_run_d;
      age_q    <= age_d;
    end
  end

  // pin contract checks; all but retire_clear_a and pulse_width_a, which watch the internal idle and high-run counts, watch what the block drives
  status_reset_low_a: assert property (@(posedge core_clk)
    rst |=> !test_status_out) else $error("status not low in reset");
  bist_start_high_a: assert property (@(posedge core_clk) disable iff (rst)
    bist.start |=> test_status_out) else $error("no high at start");
  bist_pass_low_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == TSB_RUN && bist.done && bist.pass && !bist.start
     && pulse_d == '0) |=> !test_status_out)
    else $error("status not low after pass");
  bist_fail_high_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == TSB_RUN && bist.done && !bist.pass) |=>
    test_status_out [*2]) else $error("fail not held");
  timeout_fire_a: assert property (@(posedge core_clk) disable iff (rst)
    (idle_q == LIMIT_M1 && !retire) |=> timeout_reset)
    else $error("timeout missed");
  pulse_width_a: assert property (@(posedge core_clk) disable iff (rst)
    hi_run_q <= (PULSE_W+1)'(PULSE_CYCLES))
    else $error("pulse too long");
  pulse_start_a: assert property (@(posedge core_clk) disable iff (rst)
    timeout_reset |=> test_status_out) else $error("no pulse");
  seq_once_a: assert property (@(posedge core_clk) disable iff (rst)
    seq_start |=> !seq_start) else $error("start repeated");
  retire_clear_a: assert property (@(posedge core_clk) disable iff (rst)
    retire |=> idle_q == '0) else $error("count not cleared");

  // count, pulse and drive checks
  count_step_a: assert property (@(posedge core_clk) disable iff (rst)
    (!retire && idle_q != LIMIT_M1) |=> idle_q == $past(idle_q) + 1'b1)
    else $error("idle count stalled");
  timeout_once_a: assert property (@(posedge core_clk) disable iff (rst)
    timeout_reset |=> !timeout_reset) else $error("timeout repeated");
  pulse_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    (age_q != '0 && age_q != AGE_END) |-> test_status_out)
    else $error("pulse dropped early");
  pulse_end_a: assert property (@(posedge core_clk) disable iff (rst)
    (age_q == AGE_END && state_q == TSB_IDLE) |-> !test_status_out)
    else $error("pulse held too long");
  fail_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == TSB_FAIL && !bist.start) |=> test_status_out)
    else $error("fail dropped");
  reset_drive_a: assert property (@(posedge core_clk)
    rst |=> test_status_oe) else $error("pin not driven in reset");

  // main scenarios: pass, fail, timeout and the reset sequence start
  bist_pass_c: cover property (@(posedge core_clk) disable iff (rst)
    state_q == TSB_RUN && bist.done && bist.pass);
  bist_fail_c: cover property (@(posedge core_clk) disable iff (rst)
    state_q == TSB_FAIL);
  timeout_c: cover property (@(posedge core_clk) disable iff (rst)
    timeout_reset);
  seq_start_c: cover property (@(posedge core_clk) disable iff (rst)
    seq_start);
endmodule

// File: tb/tsb_tester_model.sv
// tester model: samples the status pin, measures high pulses
`timescale 1ns/100ps
module tsb_tester_model (
  // clock
  input  wire logic        core_clk,
  // status pin from the device
  input  wire logic        test_status_out,
  input  wire logic        test_status_oe,
  // seen level and width of the last high pulse
  output logic             pin_level,
  output logic [15:0]      high_len
);
  logic [15:0] run_q = 16'h0000;
  // pull-up wins whenever the device lets go
  assign pin_level = test_status_oe ? test_status_out : 1'b1;
  // width is latched only at the fall, so a restarted pulse counts whole
  always @(posedge core_clk) begin
    if (pin_level === 1'b1) run_q <= run_q + 16'h0001;
    else begin
      if (run_q != 0) high_len <= run_q;
      run_q <= 16'h0000;
    end
  end
endmodule

// File: tb/tsb_test_status_tb.sv
// self-checking bench for the test status block
`timescale 1ns/100ps
module tsb_test_status_tb;
  import tsb_pkg::*;
  logic core_clk = 0, rst = 1, supply_good_in = 0, retire = 1;
  tsb_bist_type bist = '0;
  logic st, oe, tmo, seq, pin;
  logic [15:0] hlen;
  int n_mismatch = 0, comparisons = 0, n, n_tmo = 0;
  localparam int SIM_LIMIT = 50; // idle limit shortened for simulation
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (tmo === 1'b1) n_tmo <= n_tmo + 1;
  tsb_test_status #(.TIMEOUT_LIMIT(SIM_LIMIT)) tsb_test_status_inst (
    .core_clk(core_clk), .rst(rst), .supply_good_in(supply_good_in),
    .bist(bist), .retire(retire), .test_status_out(st),
    .test_status_oe(oe), .timeout_reset(tmo), .seq_start(seq));
  tsb_tester_model tsb_tester_model_inst (.core_clk(core_clk),
    .test_status_out(st), .test_status_oe(oe), .pin_level(pin),
    .high_len(hlen));
  task check(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // one-cycle pulse on the self-test event lines
  task bev(input logic s, d, p);
    @(posedge core_clk) bist <= '{s, d, p};
    @(posedge core_clk) bist <= '0;
    #1;
  endtask
  // bounded wait for a one-cycle output
  task wait_on(input bit use_seq);
    n = 0;
    while ((use_seq ? seq : tmo) !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    if (n == 100) begin
      n_mismatch++;
      close_out();
    end
  endtask
  task t_reset;
    tick(2);
    check(pin, 0);
    check(oe, 1);
    @(posedge core_clk) supply_good_in <= 1;
    tick(1);
    @(posedge core_clk) rst <= 0;
    wait_on(1);
    check(n, 3);
    $display("t_reset done");
  endtask
  task t_pass;
    bev(1, 0, 0);
    check(pin, 1);
    check(oe, 0);
    tick(5);
    bev(0, 1, 1);
    check(pin, 0);
    $display("t_pass done");
  endtask
  task t_fail;
    bev(1, 0, 0);
    bev(0, 1, 0);
    tick(20);
    check(pin, 1);
    bev(1, 0, 0);
    bev(0, 1, 1);
    check(pin, 0);
    $display("t_fail done");
  endtask
  task t_timeout;
    @(posedge core_clk) retire <= 0;
    wait_on(0);
    check(n, SIM_LIMIT);
    @(posedge core_clk) retire <= 1;
    tick(270);
    check(n_tmo, 1);
    check(hlen, 256);
    check(pin, 0);
    $display("t_timeout done");
  endtask
  // idle spans of 41 split by one retire never time out
  task t_restart;
    n = n_tmo;
    @(posedge core_clk) retire <= 0;
    tick(40);
    @(posedge core_clk) retire <= 1;
    @(posedge core_clk) retire <= 0;
    tick(40);
    @(posedge core_clk) retire <= 1;
    tick(2);
    check(n_tmo, n);
    $display("t_restart done");
  endtask
  initial begin
    t_reset();
    t_pass();
    t_fail();
    t_timeout();
    t_restart();
    close_out();
  end
endmodule
